// ---- rtl/cpu_end.sv ----
`timescale 1ns/1ps
module cpu_end (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // link
  coproc_if.cpu            link,
  // instruction issue
  input  wire logic        instr_valid_i,
  input  wire logic [31:0] instr_i,
  output logic             instr_ready_o,
  output logic             done_o,
  output logic             undef_trap_o,
  // processor state
  input  wire logic [3:0]  flags_i,
  input  wire logic [31:0] pc_i,
  output logic [3:0]       reg_rd_addr_o,
  input  wire logic [31:0] reg_rd_data_i,
  // results
  output logic             reg_wr_o,
  output logic [3:0]       reg_wr_addr_o,
  output logic [31:0]      reg_wr_data_o,
  output logic             flags_wr_o,
  output logic [3:0]       flags_o
);
  coproc_pkg::cpu_state_e state;
  coproc_pkg::cpu_state_e next_state;
  logic [31:0] instr;
  logic [31:0] next_instr;
  logic [31:0] dout;
  logic [31:0] next_dout;
  logic        next_done;
  logic        next_trap;
  logic        next_reg_wr;
  logic [3:0]  next_reg_wr_addr;
  logic [31:0] next_reg_wr_data;
  logic        next_flags_wr;
  logic [3:0]  next_flags;
  logic        is_xfer;
  logic        is_undef;
  logic        dir_in;
  logic [3:0]  rd;

  function automatic logic cond_pass(input logic [3:0] c,
                                     input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    case (coproc_pkg::cond_e'(c))
      coproc_pkg::COND_EQ: cond_pass = z;
      coproc_pkg::COND_NE: cond_pass = !z;
      coproc_pkg::COND_CS: cond_pass = cy;
      coproc_pkg::COND_CC: cond_pass = !cy;
      coproc_pkg::COND_MI: cond_pass = n;
      coproc_pkg::COND_PL: cond_pass = !n;
      coproc_pkg::COND_VS: cond_pass = v;
      coproc_pkg::COND_VC: cond_pass = !v;
      coproc_pkg::COND_HI: cond_pass = cy && !z;
      coproc_pkg::COND_LS: cond_pass = !cy || z;
      coproc_pkg::COND_GE: cond_pass = (n == v);
      coproc_pkg::COND_LT: cond_pass = (n != v);
      coproc_pkg::COND_GT: cond_pass = !z && (n == v);
      coproc_pkg::COND_LE: cond_pass = z || (n != v);
      coproc_pkg::COND_AL: cond_pass = 1'b1;
      default:             cond_pass = 1'b0;
    endcase
  endfunction : cond_pass

  // decode of the word offered at the issue port
  assign is_xfer  = (instr_i[coproc_pkg::CLASS_MSB:coproc_pkg::CLASS_LSB]
                     == coproc_pkg::CLASS_REG_XFER)
                    && instr_i[coproc_pkg::MARK_BIT];
  assign is_undef = (instr_i[coproc_pkg::UNDEF_MSB:coproc_pkg::UNDEF_LSB]
                     == coproc_pkg::UNDEF_CLASS)
                    && instr_i[coproc_pkg::MARK_BIT];
  assign dir_in = instr[coproc_pkg::DIR_BIT];
  assign rd     = instr[coproc_pkg::RD_MSB:coproc_pkg::RD_LSB];

  assign instr_ready_o = (state == coproc_pkg::CPU_IDLE);
  assign reg_rd_addr_o = instr_i[coproc_pkg::RD_MSB:coproc_pkg::RD_LSB];

  assign link.instr = instr;
  assign link.cpi   = (state == coproc_pkg::CPU_OFFER)
                      || (state == coproc_pkg::CPU_BUSY)
                      || (state == coproc_pkg::CPU_PREP);

  // cycle type shown for the current cycle
  always_comb begin
    case (state)
      coproc_pkg::CPU_OFFER:
        {link.memory_request_low, link.sequential_flag} =
          coproc_pkg::CYC_SEQ;
      coproc_pkg::CPU_XFER:
        {link.memory_request_low, link.sequential_flag} =
          coproc_pkg::CYC_XFER;
      default:
        {link.memory_request_low, link.sequential_flag} =
          coproc_pkg::CYC_INT;
    endcase
  end

  assign link.dev_d      = dout;
  assign link.dev_d_oe_n = !((state == coproc_pkg::CPU_XFER) && !dir_in);

  always_comb begin
    next_state       = state;
    next_instr       = instr;
    next_dout        = dout;
    next_done        = 1'b0;
    next_trap        = 1'b0;
    next_reg_wr      = 1'b0;
    next_reg_wr_addr = reg_wr_addr_o;
    next_reg_wr_data = reg_wr_data_o;
    next_flags_wr    = 1'b0;
    next_flags       = flags_o;
    case (state)
      coproc_pkg::CPU_IDLE: begin
        if (instr_valid_i) begin
          if (!cond_pass(instr_i[coproc_pkg::COND_MSB:coproc_pkg::COND_LSB],
                         flags_i) || !(is_xfer || is_undef)) begin
            next_done = 1'b1;
          end else begin
            next_state = coproc_pkg::CPU_OFFER;
            next_instr = instr_i;
            if (reg_rd_addr_o == coproc_pkg::PC_REG)
              next_dout = pc_i + coproc_pkg::PC_OFFSET;
            else
              next_dout = reg_rd_data_i;
          end
        end
      end
      coproc_pkg::CPU_OFFER, coproc_pkg::CPU_BUSY: begin
        if (link.coproc_absent_line) begin
          next_state = coproc_pkg::CPU_IDLE;
          next_trap  = 1'b1;
          next_done  = 1'b1;
        end else if (link.coproc_busy_line) begin
          next_state = coproc_pkg::CPU_BUSY;
        end else if (dir_in) begin
          next_state = coproc_pkg::CPU_XFER;
        end else begin
          next_state = coproc_pkg::CPU_PREP;
        end
      end
      coproc_pkg::CPU_PREP: begin
        next_state = coproc_pkg::CPU_XFER;
      end
      coproc_pkg::CPU_XFER: begin
        next_state = coproc_pkg::CPU_IDLE;
        next_done  = 1'b1;
        if (dir_in) begin
          if (rd == coproc_pkg::PC_REG) begin
            next_flags_wr = 1'b1;
            next_flags    =
              link.bus_d[coproc_pkg::FLAG_MSB:coproc_pkg::FLAG_LSB];
          end else begin
            next_reg_wr      = 1'b1;
            next_reg_wr_addr = rd;
            next_reg_wr_data = link.bus_d;
          end
        end
      end
      default: next_state = coproc_pkg::CPU_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state         <= coproc_pkg::CPU_IDLE;
      instr         <= 32'h00000000;
      dout          <= 32'h00000000;
      done_o        <= 1'b0;
      undef_trap_o  <= 1'b0;
      reg_wr_o      <= 1'b0;
      reg_wr_addr_o <= 4'h0;
      reg_wr_data_o <= 32'h00000000;
      flags_wr_o    <= 1'b0;
      flags_o       <= 4'h0;
    end else begin
      state         <= next_state;
      instr         <= next_instr;
      dout          <= next_dout;
      done_o        <= next_done;
      undef_trap_o  <= next_trap;
      reg_wr_o      <= next_reg_wr;
      reg_wr_addr_o <= next_reg_wr_addr;
      reg_wr_data_o <= next_reg_wr_data;
      flags_wr_o    <= next_flags_wr;
      flags_o       <= next_flags;
    end
  end
endmodule : cpu_end

// ---- rtl/coproc_pkg.sv ----
package coproc_pkg;
  // instruction word fields
  localparam int COND_MSB  = 31;
  localparam int COND_LSB  = 28;
  localparam int CLASS_MSB = 27;
  localparam int CLASS_LSB = 24;
  localparam int UNDEF_MSB = 27;
  localparam int UNDEF_LSB = 25;
  localparam int OPC_MSB   = 23;
  localparam int OPC_LSB   = 21;
  localparam int DIR_BIT   = 20;
  localparam int CRN_MSB   = 19;
  localparam int CRN_LSB   = 16;
  localparam int RD_MSB    = 15;
  localparam int RD_LSB    = 12;
  localparam int NUM_MSB   = 11;
  localparam int NUM_LSB   = 8;
  localparam int INFO_MSB  = 7;
  localparam int INFO_LSB  = 5;
  localparam int MARK_BIT  = 4;
  localparam int CRM_MSB   = 3;
  localparam int CRM_LSB   = 0;
  localparam logic [3:0] CLASS_REG_XFER = 4'hE;
  localparam logic [2:0] UNDEF_CLASS    = 3'h3;
  localparam int         COPROC_NUM_MAX = 15;

  // transferred word bits copied into negative, zero, carry, overflow
  localparam int FLAG_MSB = 31;
  localparam int FLAG_LSB = 28;

  localparam logic [3:0]  PC_REG    = 4'hF;
  localparam logic [31:0] PC_OFFSET = 32'h0000000C;

  // {memory_request_low, sequential_flag}
  localparam logic [1:0] CYC_SEQ  = 2'h1;
  localparam logic [1:0] CYC_INT  = 2'h2;
  localparam logic [1:0] CYC_XFER = 2'h3;

  typedef enum logic [3:0] {
    COND_EQ = 4'h0, COND_NE = 4'h1, COND_CS = 4'h2, COND_CC = 4'h3,
    COND_MI = 4'h4, COND_PL = 4'h5, COND_VS = 4'h6, COND_VC = 4'h7,
    COND_HI = 4'h8, COND_LS = 4'h9, COND_GE = 4'hA, COND_LT = 4'hB,
    COND_GT = 4'hC, COND_LE = 4'hD, COND_AL = 4'hE, COND_NV = 4'hF
  } cond_e;

  typedef enum logic [2:0] {
    CPU_IDLE  = 3'h0,
    CPU_OFFER = 3'h1,
    CPU_BUSY  = 3'h2,
    CPU_PREP  = 3'h3,
    CPU_XFER  = 3'h4
  } cpu_state_e;

  typedef enum logic [0:0] {
    COP_IDLE = 1'h0,
    COP_ENG  = 1'h1
  } cop_state_e;
endpackage : coproc_pkg

// ---- rtl/coproc_if.sv ----
`timescale 1ns/1ps
interface coproc_if;
  logic [31:0] instr;
  logic        cpi;
  logic        coproc_absent_line;
  logic        coproc_busy_line;
  logic        memory_request_low;
  logic        sequential_flag;
  logic [31:0] dev_d;
  logic        dev_d_oe_n;
  logic [31:0] cop_d;
  logic        cop_d_oe_n;
  logic [31:0] bus_d;

  // shared data bus level worked out from the two enables
  assign bus_d = !dev_d_oe_n ? dev_d : (!cop_d_oe_n ? cop_d : 32'h00000000);

  modport cpu (
    output instr, cpi, memory_request_low, sequential_flag,
    output dev_d, dev_d_oe_n,
    input  coproc_absent_line, coproc_busy_line, bus_d
  );
  modport cop (
    input  instr, cpi, memory_request_low, sequential_flag, bus_d,
    output coproc_absent_line, coproc_busy_line, cop_d, cop_d_oe_n
  );
endinterface : coproc_if

// ---- rtl/coproc_end.sv ----
`timescale 1ns/1ps
module coproc_end #(
  parameter logic [3:0] CP_NUM      = 4'h0,
  parameter int         BUSY_CYCLES = 2
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // link
  coproc_if.cop            link,
  // user side
  input  wire logic        present_i,
  input  wire logic        load_en_i,
  input  wire logic [3:0]  load_reg_i,
  input  wire logic [31:0] load_data_i,
  output logic             wr_o,
  output logic [3:0]       wr_reg_o,
  output logic [31:0]      wr_data_o
);
  // busy counter is eight bits wide
  if (BUSY_CYCLES < 0 || BUSY_CYCLES > 255) begin : g_bad_busy
    $error("coproc_end: BUSY_CYCLES out of range");
  end

  localparam logic [7:0] BUSY_INIT = 8'(BUSY_CYCLES);

  coproc_pkg::cop_state_e state;
  coproc_pkg::cop_state_e next_state;
  logic [7:0]  cnt;
  logic [7:0]  next_cnt;
  logic        dir;
  logic        next_dir;
  logic [3:0]  coproc_primary_reg;
  logic [3:0]  next_crn;
  logic [31:0] dreg;
  logic [31:0] next_dreg;
  logic        next_wr;
  logic [3:0]  next_wr_reg;
  logic [31:0] next_wr_data;
  logic [31:0] regs [16];
  logic        hit;
  logic        c_cycle;

  // own number only
  // only a register transfer carrying our number is taken
  assign hit = present_i && link.cpi && (state == coproc_pkg::COP_IDLE)
    && (link.instr[coproc_pkg::CLASS_MSB:coproc_pkg::CLASS_LSB]
        == coproc_pkg::CLASS_REG_XFER)
    && link.instr[coproc_pkg::MARK_BIT]
    && (link.instr[coproc_pkg::NUM_MSB:coproc_pkg::NUM_LSB] == CP_NUM);
  assign c_cycle = link.memory_request_low && link.sequential_flag;

  // refuse both high
  // handshake lines; idle or absent unit refuses with both high
  always_comb begin
    if (state == coproc_pkg::COP_ENG) begin
      link.coproc_absent_line = 1'b0;
      link.coproc_busy_line   = (cnt != 8'h00);
    end else if (hit) begin
      link.coproc_absent_line = 1'b0;
      link.coproc_busy_line   = (BUSY_INIT != 8'h00);
    end else begin
      link.coproc_absent_line = 1'b1;
      link.coproc_busy_line   = 1'b1;
    end
  end

  assign link.cop_d      = dreg;
  assign link.cop_d_oe_n = !((state == coproc_pkg::COP_ENG) && dir
                             && c_cycle && (cnt == 8'h00));

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_dir     = dir;
    next_crn     = coproc_primary_reg;
    next_dreg    = dreg;
    next_wr      = 1'b0;
    next_wr_reg  = wr_reg_o;
    next_wr_data = wr_data_o;
    case (state)
      coproc_pkg::COP_IDLE: begin
        if (hit) begin
          next_state = coproc_pkg::COP_ENG;
          next_cnt   = (BUSY_INIT != 8'h00) ? BUSY_INIT - 8'h01 : 8'h00;
          next_dir   = link.instr[coproc_pkg::DIR_BIT];
          next_crn   = link.instr[coproc_pkg::CRN_MSB:coproc_pkg::CRN_LSB];
          next_dreg  =
            regs[link.instr[coproc_pkg::CRN_MSB:coproc_pkg::CRN_LSB]];
        end
      end
      coproc_pkg::COP_ENG: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (c_cycle) begin
          next_state = coproc_pkg::COP_IDLE;
          if (!dir) begin
            next_wr      = 1'b1;
            next_wr_reg  = coproc_primary_reg;
            next_wr_data = link.bus_d;
          end
        end else if (!link.cpi) begin
          // processor gave up on the instruction
          next_state = coproc_pkg::COP_IDLE;
        end
      end
      default: next_state = coproc_pkg::COP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state     <= coproc_pkg::COP_IDLE;
      cnt       <= 8'h00;
      dir       <= 1'b0;
      coproc_primary_reg       <= 4'h0;
      dreg      <= 32'h00000000;
      wr_o      <= 1'b0;
      wr_reg_o  <= 4'h0;
      wr_data_o <= 32'h00000000;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      dir       <= next_dir;
      coproc_primary_reg       <= next_crn;
      dreg      <= next_dreg;
      wr_o      <= next_wr;
      wr_reg_o  <= next_wr_reg;
      wr_data_o <= next_wr_data;
    end
  end

  // register file; a transfer write wins over a user load
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 16; i++) regs[i] <= 32'h00000000;
    end else if (next_wr) begin
      regs[next_wr_reg] <= next_wr_data;
    end else if (load_en_i) begin
      regs[load_reg_i] <= load_data_i;
    end
  end
endmodule : coproc_end

// ---- testbench/coproc_checker.sv ----
`timescale 1ns/1ps
module coproc_checker (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  // link signals
  input wire logic [31:0] instr,
  input wire logic        cpi,
  input wire logic        coproc_absent_line,
  input wire logic        coproc_busy_line,
  input wire logic        memory_request_low,
  input wire logic        sequential_flag,
  input wire logic        dev_d_oe_n,
  input wire logic        cop_d_oe_n
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  logic [1:0] ty;
  assign ty = {memory_request_low, sequential_flag};

  // accepted in offer or last busy cycle; past busy low marks prep
  sequence accept_s;
    cpi && !coproc_busy_line && !coproc_absent_line &&
    (sequential_flag || $past(coproc_busy_line));
  endsequence

  AST_OFFER_SEQ: assert property (
    $rose(cpi) |-> ty == coproc_pkg::CYC_SEQ)
    else $error("offer cycle not sequential");
  AST_BUSY_WAIT: assert property (
    cpi && coproc_busy_line && !coproc_absent_line
    |=> cpi && ty == coproc_pkg::CYC_INT)
    else $error("busy did not hold internal cycle");
  AST_MRC_XFER: assert property (
    accept_s ##0 instr[coproc_pkg::DIR_BIT]
    |=> ty == coproc_pkg::CYC_XFER && !cop_d_oe_n)
    else $error("inbound transfer cycle missing");
  AST_MCR_XFER: assert property (
    accept_s ##0 !instr[coproc_pkg::DIR_BIT]
    |=> ty == coproc_pkg::CYC_INT ##1
        ty == coproc_pkg::CYC_XFER && !dev_d_oe_n)
    else $error("outbound extra internal cycle missing");
  AST_C_ONCE: assert property (
    ty == coproc_pkg::CYC_XFER |-> !cpi ##1 ty == coproc_pkg::CYC_INT)
    else $error("transfer cycle not single");
  AST_DRIVE_C: assert property (
    !dev_d_oe_n || !cop_d_oe_n |-> ty == coproc_pkg::CYC_XFER)
    else $error("bus driven outside transfer cycle");
  AST_DIR: assert property (
    !dev_d_oe_n |-> !instr[coproc_pkg::DIR_BIT] && cop_d_oe_n)
    else $error("device drives on inbound move");
  AST_FIELDS: assert property (
    cpi && $past(cpi) |-> $stable(instr))
    else $error("instruction changed during offer");
  AST_TRAP: assert property (
    cpi && coproc_absent_line |=> !cpi && ty == coproc_pkg::CYC_INT)
    else $error("refused offer not ended");

  cover property (!cop_d_oe_n);
  cover property (!dev_d_oe_n);
  cover property (cpi && coproc_absent_line);
  cover property (cpi && coproc_busy_line);
endmodule : coproc_checker

// ---- testbench/coproc_register_transfer_port_tb.sv ----
`timescale 1ns/1ps
module coproc_register_transfer_port_tb;
  localparam int         B   = 2;
  localparam logic [3:0] NUM = 4'h5;
  localparam logic [3:0] AL  = coproc_pkg::COND_AL;
  localparam logic [3:0] PCR = coproc_pkg::PC_REG;
  logic        sys_clk_i     = 1'b0;
  logic        resetn_i      = 1'b0;
  logic        instr_valid_i = 1'b0;
  logic [31:0] instr_i       = 32'h00000000;
  logic [3:0]  flags_i       = 4'h0;
  logic [31:0] pc_i          = 32'h00000000;
  logic [31:0] reg_rd_data_i = 32'h00000000;
  logic        present_i     = 1'b1;
  logic        load_en_i     = 1'b0;
  logic [3:0]  load_reg_i    = 4'h0;
  logic [31:0] load_data_i   = 32'h00000000;
  logic        instr_ready_o, done_o, undef_trap_o;
  logic        reg_wr_o, flags_wr_o, wr_o;
  logic [3:0]  reg_rd_addr_o, reg_wr_addr_o, flags_o, wr_reg_o;
  logic [31:0] reg_wr_data_o, wr_data_o;
  int          fails   = 0;
  int          checked = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  coproc_if i_coproc_if ();
  cpu_end i_cpu_end (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(i_coproc_if),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_ready_o(instr_ready_o), .done_o(done_o),
    .undef_trap_o(undef_trap_o), .flags_i(flags_i), .pc_i(pc_i),
    .reg_rd_addr_o(reg_rd_addr_o), .reg_rd_data_i(reg_rd_data_i),
    .reg_wr_o(reg_wr_o), .reg_wr_addr_o(reg_wr_addr_o),
    .reg_wr_data_o(reg_wr_data_o), .flags_wr_o(flags_wr_o),
    .flags_o(flags_o));
  coproc_end #(.CP_NUM(NUM), .BUSY_CYCLES(B)) i_coproc_end (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(i_coproc_if),
    .present_i(present_i), .load_en_i(load_en_i),
    .load_reg_i(load_reg_i), .load_data_i(load_data_i),
    .wr_o(wr_o), .wr_reg_o(wr_reg_o), .wr_data_o(wr_data_o));
  coproc_checker i_coproc_checker (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .instr(i_coproc_if.instr), .cpi(i_coproc_if.cpi),
    .coproc_absent_line(i_coproc_if.coproc_absent_line),
    .coproc_busy_line(i_coproc_if.coproc_busy_line),
    .memory_request_low(i_coproc_if.memory_request_low),
    .sequential_flag(i_coproc_if.sequential_flag),
    .dev_d_oe_n(i_coproc_if.dev_d_oe_n),
    .cop_d_oe_n(i_coproc_if.cop_d_oe_n));

  task automatic wrap_up();
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fails++;
      $display("wrong value at %0t: %0d cycles not %0d", $time, got, exp);
    end
  endtask : chk_n

  function automatic logic [31:0] mk(input logic [3:0] c, input logic d,
      input logic [3:0] num, input logic [3:0] rd, input logic [3:0] coproc_primary_reg);
    return {c, 4'hE, 3'h5, d, coproc_primary_reg, rd, num, 3'h2, 1'b1, 4'hA};
  endfunction : mk

  task automatic load(input logic [3:0] r, input logic [31:0] v);
    @(posedge sys_clk_i);
    load_en_i   <= 1'b1;
    load_reg_i  <= r;
    load_data_i <= v;
    @(posedge sys_clk_i);
    load_en_i <= 1'b0;
  endtask : load

  // latency counted in cycles after the taking edge, seen at negedge
  task automatic run(input logic [31:0] w, input int lat);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (instr_ready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("wrong value at %0t: never ready", $time);
      wrap_up();
    end
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("wrong value at %0t: no completion", $time);
      wrap_up();
    end else begin
      chk_n(n, lat);
    end
  endtask : run

  task automatic t_mrc();
    load(4'h3, 32'hA5C30F17);
    run(mk(AL, 1'b1, NUM, 4'h7, 4'h3), B + 3);
    chk(reg_wr_o, 1'b1);
    chk(reg_wr_addr_o, 4'h7);
    chk(reg_wr_data_o, 32'hA5C30F17);
    chk(undef_trap_o, 1'b0);
  endtask : t_mrc

  task automatic t_flags();
    load(4'h9, 32'h60001234);
    flags_i <= 4'h9;
    run(mk(AL, 1'b1, NUM, PCR, 4'h9), B + 3);
    chk(flags_wr_o, 1'b1);
    chk(flags_o, 4'h6);
    chk(reg_wr_o, 1'b0);
  endtask : t_flags

  task automatic t_mcr();
    @(posedge sys_clk_i);
    pc_i          <= 32'h00001000;
    reg_rd_data_i <= 32'hDEADBEEF;
    run(mk(AL, 1'b0, NUM, PCR, 4'h2), B + 4);
    chk(wr_o, 1'b1);
    chk(wr_reg_o, 4'h2);
    chk(wr_data_o, 32'h0000100C);
    run(mk(AL, 1'b0, NUM, 4'h4, 4'hB), B + 4);
    chk(reg_rd_addr_o, 4'h4);
    chk(wr_data_o, 32'hDEADBEEF);
    // back to back read of the same coprocessor register
    run(mk(AL, 1'b1, NUM, 4'h2, 4'hB), B + 3);
    chk(reg_wr_data_o, 32'hDEADBEEF);
  endtask : t_mcr

  task automatic t_cond();
    logic [3:0] cc [4];
    logic [3:0] ff [4];
    cc = '{coproc_pkg::COND_NE, coproc_pkg::COND_EQ,
           coproc_pkg::COND_MI, coproc_pkg::COND_PL};
    ff = '{4'h4, 4'h4, 4'h0, 4'h0};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      flags_i <= ff[i];
      run(mk(cc[i], 1'b1, NUM, 4'h1, 4'h3), (i % 2) ? B + 3 : 1);
      chk(reg_wr_o, (i % 2) ? 1'b1 : 1'b0);
    end
  endtask : t_cond

  task automatic t_refuse();
    run(mk(AL, 1'b1, 4'h6, 4'h1, 4'h3), 2);
    chk(undef_trap_o, 1'b1);
    run({AL, 3'h3, 20'h00000, 1'b1, 4'h0}, 2);
    chk(undef_trap_o, 1'b1);
    chk(reg_wr_o, 1'b0);
    @(posedge sys_clk_i);
    present_i <= 1'b0;
    run(mk(AL, 1'b1, NUM, 4'h1, 4'h3), 2);
    chk(undef_trap_o, 1'b1);
    chk(reg_wr_o, 1'b0);
    @(posedge sys_clk_i);
    present_i <= 1'b1;
  endtask : t_refuse

  initial begin
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_mrc();
    t_flags();
    t_mcr();
    t_cond();
    t_refuse();
    wrap_up();
  end
endmodule : coproc_register_transfer_port_tb
